// >>> pccs_pkg.sv
// package: configuration offsets, field positions and reset values of the command/status block
package pccs_pkg;
    // configuration byte offsets
    localparam logic [7:0]  PCCS_OFS_IDENT   = 8'h02;
    localparam logic [7:0]  PCCS_OFS_COMMAND = 8'h04;
    localparam logic [7:0]  PCCS_OFS_STATUS  = 8'h06;
    // command field positions
    localparam int PCCS_CMD_IO     = 0;
    localparam int PCCS_CMD_MEM    = 1;
    localparam int PCCS_CMD_MASTER = 2;
    localparam int PCCS_CMD_SPEC   = 3;
    localparam int PCCS_CMD_MWI    = 4;
    localparam int PCCS_CMD_PAL    = 5;
    localparam int PCCS_CMD_PERR   = 6;
    localparam int PCCS_CMD_STEP   = 7;
    localparam int PCCS_CMD_SERR   = 8;
    localparam int PCCS_CMD_FBB    = 9;
    // status field positions
    localparam int PCCS_STA_CAP    = 4;
    localparam int PCCS_STA_MDPE   = 8;
    localparam int PCCS_STA_TIM_LO = 9;
    localparam int PCCS_STA_TAS    = 11;
    localparam int PCCS_STA_TAR    = 12;
    localparam int PCCS_STA_MAR    = 13;
    localparam int PCCS_STA_SSE    = 14;
    localparam int PCCS_STA_DPE    = 15;
    // writable command bits, sticky status bits, reset values
    localparam logic [15:0] PCCS_CMD_WMASK  = 16'h0156;
    localparam logic [15:0] PCCS_STA_STICKY = 16'hf900;
    localparam logic [15:0] PCCS_CMD_RESET  = 16'h0000;
    localparam logic [15:0] PCCS_STA_RESET  = 16'h0210;
    localparam logic [15:0] PCCS_STA_FIXED  = 16'h0210;
    // events reported by the bus engine, one-cycle pulses
    typedef struct packed {
        logic addr_parity_err;   // address parity error seen
        logic data_parity_err;   // data parity error seen by own checker
        logic perr_seen;         // parity-error line asserted by any agent
        logic master_phase;      // this device is master of the current data phase
        logic master_abort;      // own master cycle ended by master abort
        logic target_abort_rx;   // own master cycle ended by target abort
        logic target_abort_tx;   // device as target ended with target abort
    } pccs_evt_s;
    // configuration access
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [7:0]  addr;       // byte offset of a 16-bit half
        logic [1:0]  be;         // byte enables of that half
        logic [15:0] wdata;
    } pccs_acc_s;
endpackage : pccs_pkg

// >>> pccs_regs.sv
// command/status register bank of the configuration header with error capture
import pccs_pkg::*;
// Functional notes
// - offset 02h reads a fixed 16-bit identification code; writes ignored
// - command bits 15..10 read zero and ignore writes
// - command bit 9 back-to-back enable reads zero
// - command bit 8 writable; enables driving system error after address parity error
// - command bit 7 stepping control hardwired zero
// - command bit 6 writable; enables driving parity-error signal
// - command bit 5 palette snoop reads zero
// - command bit 4 writable; selects write-and-invalidate over plain write
// - command bit 3 reads zero; special cycles ignored
// - command bit 2 writable; mastering allowed only while set
// - command bit 1 writable; memory target response only while set
// - command bit 0 io space enable reads zero
// - status bit 15 sets on any address or data parity error, sticky
// - status bit 14 sets when system error was signalled while enabled
// - status bit 13 sets on master abort of own cycle
// - status bit 12 sets on target abort received by own cycle
// - status bit 11 sets when device as target signals target abort
// - status bits 10..9 hardwired 01b, medium select timing
// - status bit 8 needs parity-error line, own master phase and bit 6
// - status bits 7, 6, 5 read zero
// - status bit 4 reads one; bits 3..0 read zero
// - error bits clear only by writing one; zero leaves them
module pccs_regs #(
    parameter logic [15:0] IDENT_CODE = 16'h5a5a  // arbitrary identification value
) (
    input  wire logic        i_mclk,
    input  wire logic        i_nrst,
    input  wire pccs_acc_s   i_acc,
    input  wire pccs_evt_s   i_evt,
    output logic [15:0]      o_rdata,
    output logic             o_rvalid,
    output logic             o_mem_target_en,
    output logic             o_master_en,
    output logic             o_mwi_en,
    output logic             o_perr_drive,
    output logic             o_serr_drive
);
    logic [15:0] cmd_q;
    logic [15:0] sta_q;
    logic [15:0] rdata_q;
    logic        rvalid_q;
    logic        perr_q;
    logic        serr_q;
    logic [15:0] sta_set;
    logic [15:0] wbits;
    logic        serr_fire;

    // byte-lane write mask; a lane not enabled writes nothing
    function automatic logic [15:0] lane_mask(input logic [1:0] be);
        return {{8{be[1]}}, {8{be[0]}}};
    endfunction

    assign wbits = i_acc.wdata & lane_mask(i_acc.be);
    // system error only goes out when enabled and an address parity error was seen
    assign serr_fire = cmd_q[PCCS_CMD_SERR] && i_evt.addr_parity_err;

    // hardware set terms for the sticky status bits
    always_comb begin
        sta_set = 16'h0000;
        sta_set[PCCS_STA_DPE] = i_evt.addr_parity_err | i_evt.data_parity_err;
        sta_set[PCCS_STA_SSE] = serr_fire;
        sta_set[PCCS_STA_MAR] = i_evt.master_abort;
        sta_set[PCCS_STA_TAR] = i_evt.target_abort_rx;
        sta_set[PCCS_STA_TAS] = i_evt.target_abort_tx;
        sta_set[PCCS_STA_MDPE] = i_evt.perr_seen && i_evt.master_phase
                                 && cmd_q[PCCS_CMD_PERR];
    end

    // command: only the writable bits ever hold a one
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            cmd_q <= PCCS_CMD_RESET;
        end else if (i_acc.wr && i_acc.addr == PCCS_OFS_COMMAND) begin
            cmd_q <= (cmd_q & ~(lane_mask(i_acc.be) & PCCS_CMD_WMASK))
                     | (wbits & PCCS_CMD_WMASK);
        end
    end

    // status: write-one-to-clear; a set in the same cycle wins over the clear
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            sta_q <= PCCS_STA_RESET;
        end else begin
            if (i_acc.wr && i_acc.addr == PCCS_OFS_STATUS) begin
                sta_q <= ((sta_q & ~(wbits & PCCS_STA_STICKY)) | sta_set)
                         & PCCS_STA_STICKY | PCCS_STA_FIXED;
            end else begin
                sta_q <= ((sta_q | sta_set) & PCCS_STA_STICKY)
                         | PCCS_STA_FIXED;
            end
        end
    end

    // read data registered one cycle after the request; unmapped offsets read zero
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            rdata_q  <= 16'h0000;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= i_acc.rd;
            if (!i_acc.rd) begin
                rdata_q <= 16'h0000;
            end else begin
                unique case (i_acc.addr)
                    PCCS_OFS_IDENT:   rdata_q <= IDENT_CODE;
                    PCCS_OFS_COMMAND: rdata_q <= cmd_q;
                    PCCS_OFS_STATUS:  rdata_q <= sta_q;
                    default:          rdata_q <= 16'h0000;
                endcase
            end
        end
    end

    // pin drives follow the detection by one cycle
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            perr_q <= 1'b0;
            serr_q <= 1'b0;
        end else begin
            perr_q <= cmd_q[PCCS_CMD_PERR] &&
                      (i_evt.data_parity_err || i_evt.addr_parity_err);
            serr_q <= serr_fire;
        end
    end

    assign o_rdata         = rdata_q;
    assign o_rvalid        = rvalid_q;
    assign o_mem_target_en = cmd_q[PCCS_CMD_MEM];
    assign o_master_en     = cmd_q[PCCS_CMD_MASTER];
    assign o_mwi_en        = cmd_q[PCCS_CMD_MWI] && cmd_q[PCCS_CMD_MASTER];
    assign o_perr_drive    = perr_q;
    assign o_serr_drive    = serr_q;

    // checks
    a_ident_fixed: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        i_acc.rd && i_acc.addr == PCCS_OFS_IDENT |=> o_rdata == IDENT_CODE)
        else $error("identification word wrong");
    a_cmd_ro_zero: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        (cmd_q & ~PCCS_CMD_WMASK) == 16'h0000)
        else $error("read-only command bit set");
    a_serr_gate: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        o_serr_drive |-> $past(cmd_q[PCCS_CMD_SERR]) && $past(i_evt.addr_parity_err))
        else $error("system error driven without cause");
    a_perr_gate: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        i_evt.data_parity_err && !cmd_q[PCCS_CMD_PERR] |=> !o_perr_drive)
        else $error("parity error driven while disabled");
    a_dpe_sets: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        i_evt.data_parity_err |=> sta_q[PCCS_STA_DPE])
        else $error("parity status not set");
    a_mdpe_cond: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        $rose(sta_q[PCCS_STA_MDPE]) |-> $past(i_evt.perr_seen && i_evt.master_phase
                                        && cmd_q[PCCS_CMD_PERR]))
        else $error("master parity status set without all conditions");
    a_fixed_status: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        sta_q[10:0] == (PCCS_STA_FIXED[10:0] | {2'b00, sta_q[8], 8'h00}))
        else $error("fixed status bits wrong");
    a_clear_zero: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        sta_q[PCCS_STA_MAR] && !(i_acc.wr && i_acc.addr == PCCS_OFS_STATUS
            && wbits[PCCS_STA_MAR]) |=> sta_q[PCCS_STA_MAR])
        else $error("abort status lost without write of one");
    c_status_clear: cover property (@(posedge i_mclk) disable iff (!i_nrst)
        sta_q[PCCS_STA_TAS] ##1 !sta_q[PCCS_STA_TAS]);
    c_serr_out: cover property (@(posedge i_mclk) disable iff (!i_nrst) o_serr_drive);
    c_cmd_write: cover property (@(posedge i_mclk) disable iff (!i_nrst)
        i_acc.wr && i_acc.addr == PCCS_OFS_COMMAND ##1 o_master_en);
endmodule // pccs_regs

// >>> pccs_host_model.sv
// host bridge and bus engine model: configuration accesses and event pulses
module pccs_host_model
    import pccs_pkg::*;
(
    input  wire logic i_mclk,
    output pccs_acc_s o_acc,
    output pccs_evt_s o_evt
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle bus from time zero so the bank never sees an unknown request
    initial begin
        o_acc = '0;
        o_evt = '0;
    end
    // one request held for exactly one taking edge; a read when rd is set, otherwise a write
    task automatic access(input logic rd, input logic [7:0] a, input logic [1:0] be,
                          input logic [15:0] d);
        @(posedge i_mclk);
        o_acc <= '{rd, !rd, a, be, d};
        @(posedge i_mclk);
        o_acc <= '0;
    endtask
    // events are single-cycle pulses, as the bus engine makes them
    task automatic pulse(input pccs_evt_s e);
        @(posedge i_mclk);
        o_evt <= e;
        @(posedge i_mclk);
        o_evt <= '0;
    endtask
endmodule // pccs_host_model

// >>> tb_top.sv
// self-checking bench for the command/status register bank
module tb_top;
    import pccs_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] IDENT = 16'h3c96; // arbitrary identification value
    logic        i_mclk, i_nrst, o_rvalid, o_mem_target_en, o_master_en, o_mwi_en;
    logic        o_perr_drive, o_serr_drive;
    logic [15:0] o_rdata, cmd, sta, d;
    logic [1:0]  be;
    pccs_acc_s   acc;
    pccs_evt_s   evt, e;
    int          failures, num_checks;
    pccs_regs #(.IDENT_CODE(IDENT)) uut (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_acc(acc),
        .i_evt(evt), .o_rdata(o_rdata), .o_rvalid(o_rvalid), .o_mem_target_en(o_mem_target_en),
        .o_master_en(o_master_en), .o_mwi_en(o_mwi_en), .o_perr_drive(o_perr_drive),
        .o_serr_drive(o_serr_drive));
    pccs_host_model host (.i_mclk(i_mclk), .o_acc(acc), .o_evt(evt));
    initial begin
        i_mclk = 1'b0;
        forever #10 i_mclk = ~i_mclk;
    end
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    // the answer stands one cycle, so it is sampled at the falling edge after the taking edge
    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        host.access(1'b1, a, 2'h3, 16'h0000);
        @(negedge i_mclk);
        check("rvalid", 16'h0001, {15'h0000, o_rvalid});
        check("rdata", exp, o_rdata);
    endtask
    // bits of d that a write may touch: enabled lanes within mask m
    function automatic logic [15:0] lanes(input logic [1:0] b, input logic [15:0] m);
        return {{8{b[1]}}, {8{b[0]}}} & m;
    endfunction
    // status after a clean clear and one event set
    function automatic logic [15:0] flags(input pccs_evt_s v, input logic [15:0] c);
        return {v.addr_parity_err | v.data_parity_err, v.addr_parity_err & c[8], v.master_abort,
                v.target_abort_rx, v.target_abort_tx, 2'b01,
                v.perr_seen & v.master_phase & c[6], 8'h10};
    endfunction
    task automatic test_done();
        $display("checks %0d, failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // watchdog: the tests need about 460 cycles
    initial begin
        #100us;
        failures++;
        test_done();
    end
    initial begin
        failures = 0;
        num_checks = 0;
        i_nrst = 1'b0;
        cmd = 16'h0000;
        void'($urandom(32'h08c93f82));
        repeat (10) @(posedge i_mclk);
        i_nrst <= 1'b1;
        rd(PCCS_OFS_IDENT, IDENT);
        rd(PCCS_OFS_COMMAND, 16'h0000);
        rd(PCCS_OFS_STATUS, 16'h0210);
        rd(8'h08, 16'h0000);
        $display("test reset done");
        // command writes with random lanes; first pass all ones to hit every read-only bit
        for (int i = 0; i < 16; i++) begin
            d = (i == 0) ? 16'hffff : 16'($urandom);
            be = (i == 0) ? 2'h3 : 2'($urandom);
            host.access(1'b0, PCCS_OFS_COMMAND, be, d);
            cmd = (cmd & ~lanes(be, PCCS_CMD_WMASK)) | (d & lanes(be, PCCS_CMD_WMASK));
            host.access(1'b0, PCCS_OFS_IDENT, 2'h3, d);
            @(negedge i_mclk);
            check("enables", {13'h0000, cmd[1], cmd[2], cmd[4] & cmd[2]},
                  {13'h0000, o_mem_target_en, o_master_en, o_mwi_en});
            rd(PCCS_OFS_COMMAND, cmd);
            rd(PCCS_OFS_IDENT, IDENT);
        end
        $display("test command done");
        // each event alone with both drives on, then off, then random mixes
        for (int i = 0; i < 26; i++) begin
            cmd = (i < 7 || i == 15) ? 16'h0140 : (i < 16) ? 16'h0000 : 16'($urandom) & 16'h0156;
            e = (i < 14) ? pccs_evt_s'(7'h40 >> (i % 7)) : (i < 16) ? 7'h18 : 7'($urandom);
            host.access(1'b0, PCCS_OFS_COMMAND, 2'h3, cmd);
            host.access(1'b0, PCCS_OFS_STATUS, 2'h3, 16'hffff);
            host.pulse(e);
            @(negedge i_mclk);
            check("drives", {14'h0000, e.addr_parity_err & cmd[8],
                  e.data_parity_err & ~e.addr_parity_err & ~e.perr_seen & cmd[6]},
                  {14'h0000, o_serr_drive,
                  o_perr_drive & ~e.addr_parity_err & ~e.perr_seen});
            sta = flags(e, cmd);
            rd(PCCS_OFS_STATUS, sta);
            d = 16'($urandom);
            be = 2'($urandom);
            host.access(1'b0, PCCS_OFS_STATUS, be, d);
            rd(PCCS_OFS_STATUS, sta & ~(d & lanes(be, PCCS_STA_STICKY)));
        end
        $display("test status done");
        test_done();
    end
endmodule // tb_top
